/* mode_page_responder.sv */
// Mode sense and mode select responder for the configuration variable
// page and the external data page of the media_changer_unit.
// Assumes the command decoder delivers one command at a time with its page
// code, streams select parameter bytes in order and drains sense bytes.
//
// Notes on behaviour
// RULE1: configuration page byte 0 carries page code 3D hex in bits 5:0.
// RULE2: configuration page parameter length byte reads 28 hex.
// RULE3: savable_flag reads 1 on both the configuration and external pages.
// RULE4: write bit is 0 for read-only variables, 1 for changeable ones.
// RULE5: text type; length 0 means zero-terminated, up to 16 characters.
// RULE6: byte array type; length gives size, at most 16 bytes.
// RULE7: signed type; 1, 2 or 4 bytes, two's complement, MSB first.
// RULE8: unsigned type; 1, 2 or 4 bytes, MSB first.
// RULE9: length holds value size; 0 for zero-terminated strings.
// RULE10: variable name is zero-terminated, at most 20 characters.
// RULE11: 32-byte user store changed only by external page mode select.
// RULE12: external data page byte 0 carries page code 3E hex.
// RULE13: external page length 20 hex, stored bytes at positions 2 to 33.
// RULE14: unsupported page sense gives key 5, 24h/00h, C/D set, pointer 0002h.
// RULE15: select picks variable by name; each later sense returns the next.
// RULE16: byte 2 holds write, type, length; name 4-23, value 25-40.
module mode_page_responder
  import mpr_pkg::*;
(
  input  wire logic        CLK_SYS,     // System clock, 200 MHz
  input  wire logic        RST,         // Asynchronous reset, active high
  input  wire logic        CMD_VALID,   // Command offered
  output logic             CMD_READY,   // Command taken when both high
  input  wire logic        CMD_SENSE,   // 1 mode sense, 0 mode select
  input  wire logic [5:0]  CMD_PAGE,    // Page code from the command
  input  wire logic        SEL_VALID,   // Select parameter byte offered
  output logic             SEL_READY,   // Select byte taken when both high
  input  wire logic [7:0]  SEL_DATA,    // Select parameter byte
  input  wire logic        SEL_LAST,    // Last select parameter byte
  output logic             SNS_VALID,   // Sense byte offered
  input  wire logic        SNS_READY,   // Sense byte taken when both high
  output logic [7:0]       SNS_DATA,    // Sense page byte
  output logic             SNS_LAST,    // Last sense page byte
  output logic             DONE,        // Command finished, one cycle
  output logic             DONE_CHECK,  // Check condition on finish
  output logic [3:0]       SENSE_KEY,   // Sense key
  output logic [7:0]       SENSE_ASC,   // Additional sense code
  output logic [7:0]       SENSE_ASCQ,  // Additional sense qualifier
  output logic             SENSE_CD,    // Error lies in the command block
  output logic [15:0]      SENSE_FPTR   // Field pointer
);

  ////////////////////////////////////////////////////////////////////////////
  // State

  typedef struct packed {
    resp_state_e     state;
    logic            page_ext;
    logic            is_sense;
    logic [5:0]      addr;
    logic [2:0]      var_ptr;
    logic [NVAR-1:0] match;
    logic            name_end;
    logic [7:0]      data;
    logic            last;
    logic            check;
    logic [3:0]      key;
    logic [7:0]      asc;
    logic [7:0]      ascq;
    logic            cd;
    logic [15:0]     fptr;
  } resp_s;

  resp_s st;
  resp_s next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Stores

  var_table_if vt ();
  ext_store_if es ();

  config_var_table u_table (
    .tbl (vt.src)
  );

  ext_data_store u_store (
    .clk  (CLK_SYS),
    .rst  (RST),
    .port (es.store)
  );

  // Lookahead address: st.addr always names the next byte to fetch or receive
  assign vt.addr    = st.addr;
  assign es.rd_addr = 5'(st.addr - POS_EXT_FIRST);

  ////////////////////////////////////////////////////////////////////////////
  // Select byte handling

  logic sel_take;
  logic in_name;
  logic in_ext;

  assign sel_take = (st.state == ST_RECV) && SEL_VALID;
  assign in_name  = (st.addr >= POS_NAME_FIRST) && (st.addr <= POS_NAME_LAST);
  assign in_ext   = (st.addr >= POS_EXT_FIRST) && (st.addr <= POS_EXT_LAST);

  // Only the external page select reaches the store
  assign es.we      = sel_take && st.page_ext && in_ext;  // see RULE11 see RULE13
  assign es.wr_addr = 5'(st.addr - POS_EXT_FIRST);
  assign es.wr_data = SEL_DATA;

  // Each entry checks the incoming name byte against its own name lane
  logic [NVAR-1:0] name_eq;
  for (genvar i = 0; i < NVAR; i++) begin : g_cmp
    assign name_eq[i] = (SEL_DATA == vt.bytes[i]);
  end

  // Lowest matching entry wins; names are unique so at most one can match
  logic       found;
  logic [2:0] found_idx;
  always_comb begin
    found     = 1'b0;
    found_idx = VAR_FIRST;
    for (int k = NVAR - 1; k >= 0; k--) begin
      if (st.match[k] && st.name_end) begin
        found     = 1'b1;
        found_idx = 3'(k);
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sense byte source

  logic [7:0] sense_byte;
  always_comb begin
    sense_byte = vt.bytes[st.var_ptr];
    if (st.page_ext) begin
      if (st.addr == POS_CODE) begin
        sense_byte = {SAVABLE_FLAG, 1'b0, PAGE_EXT};  // see RULE12 see RULE3
      end else if (st.addr == POS_LEN) begin
        sense_byte = EXT_PARAM_LEN;  // see RULE13
      end else begin
        sense_byte = es.rd_data;  // see RULE13 see RULE11
      end
    end
  end

  logic [5:0] last_pos;
  assign last_pos = st.page_ext ? EXT_LAST_BYTE : CFG_LAST_BYTE;

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  logic page_ok;
  assign page_ok = (CMD_PAGE == PAGE_CFG) || (CMD_PAGE == PAGE_EXT);

  always_comb begin
    next_st = st;
    unique case (st.state)
      ST_IDLE: begin
        if (CMD_VALID) begin
          next_st.is_sense = CMD_SENSE;
          next_st.page_ext = (CMD_PAGE == PAGE_EXT);
          next_st.addr     = POS_CODE;
          next_st.match    = '1;
          next_st.name_end = 1'b0;
          next_st.check    = 1'b0;
          next_st.key      = KEY_NONE;
          next_st.asc      = ASC_NONE;
          next_st.ascq     = ASCQ_ZERO;
          next_st.cd       = 1'b0;
          next_st.fptr     = FPTR_NONE;
          if (!page_ok) begin
            // Unknown page: report against the page code field of the command
            next_st.state = ST_DONE;
            next_st.check = 1'b1;          // see RULE14
            next_st.key   = KEY_ILLEGAL;   // see RULE14
            next_st.asc   = ASC_BAD_CDB;   // see RULE14
            next_st.ascq  = ASCQ_ZERO;     // see RULE14
            next_st.cd    = 1'b1;          // see RULE14
            next_st.fptr  = FPTR_PAGE;     // see RULE14
          end else if (CMD_SENSE) begin
            next_st.state = ST_LOAD;
          end else begin
            next_st.state = ST_RECV;
          end
        end
      end

      ST_LOAD: begin
        // First byte is fetched before valid rises so data leaves a flip-flop
        next_st.data  = sense_byte;
        next_st.last  = 1'b0;
        next_st.addr  = 6'(st.addr + 6'h01);
        next_st.state = ST_SEND;
      end

      ST_SEND: begin
        if (SNS_READY) begin
          if (st.last) begin
            next_st.state = ST_DONE;
            if (!st.page_ext) begin
              // Each sense of the variable page moves on to the next name
              next_st.var_ptr = (st.var_ptr == VAR_LAST) ? VAR_FIRST : 3'(st.var_ptr + 3'h1);  // see RULE15
            end
          end else begin
            next_st.data = sense_byte;
            next_st.last = (st.addr == last_pos);
            next_st.addr = 6'(st.addr + 6'h01);
          end
        end
      end

      ST_RECV: begin
        if (SEL_VALID) begin
          if (!st.page_ext && in_name && !st.name_end) begin
            // Bytes past the host's terminator are not compared
            next_st.match    = st.match & name_eq;  // see RULE15
            next_st.name_end = (SEL_DATA == 8'h00);
          end
          if (st.addr != POS_MAX) begin
            next_st.addr = 6'(st.addr + 6'h01);
          end
          if (SEL_LAST) begin
            next_st.state = ST_DONE;
          end
        end
      end

      ST_DONE: begin
        next_st.state = ST_IDLE;
      end

      default: begin
        next_st.state = ST_IDLE;
      end
    endcase

    // Name lookup resolves on the cycle after the last select byte
    if (st.state == ST_DONE && !st.is_sense && !st.page_ext && !st.check) begin
      if (found) begin
        next_st.var_ptr = found_idx;  // see RULE15
      end
    end
  end

  // Unmatched names are flagged as soon as the last byte lands
  logic name_miss;
  assign name_miss = (st.state == ST_DONE) && !st.is_sense && !st.page_ext && !st.check && !found;

  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      st       <= '0;
      st.state <= ST_IDLE;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign CMD_READY  = (st.state == ST_IDLE);
  assign SEL_READY  = (st.state == ST_RECV);
  assign SNS_VALID  = (st.state == ST_SEND);
  assign SNS_DATA   = st.data;
  assign SNS_LAST   = st.last;
  assign DONE       = (st.state == ST_DONE);
  assign DONE_CHECK = st.check || name_miss;
  assign SENSE_KEY  = name_miss ? KEY_ILLEGAL : st.key;
  assign SENSE_ASC  = name_miss ? ASC_BAD_PARAM : st.asc;
  assign SENSE_ASCQ = st.ascq;
  assign SENSE_CD   = st.cd;
  assign SENSE_FPTR = name_miss ? FPTR_NAME : st.fptr;

endmodule : mode_page_responder

/* mpr_pkg.sv */
// Constants, types and the variable table for the mode page responder.
// Assumes one clock domain; every user of these names imports the package.
package mpr_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // Page codes and header bytes
  localparam logic [5:0] PAGE_CFG       = 6'h3D;
  localparam logic [5:0] PAGE_EXT       = 6'h3E;
  localparam logic       SAVABLE_FLAG   = 1'b1;
  localparam logic [7:0] CFG_PARAM_LEN  = 8'h28;
  localparam logic [7:0] EXT_PARAM_LEN  = 8'h20;

  ////////////////////////////////////////////////////////////////////////////
  // Byte positions inside the pages
  localparam logic [5:0] POS_CODE       = 6'h00;
  localparam logic [5:0] POS_LEN        = 6'h01;
  localparam logic [5:0] POS_ATTR       = 6'h02;
  localparam logic [5:0] POS_NAME_FIRST = 6'h04;
  localparam logic [5:0] POS_NAME_LAST  = 6'h17;
  localparam logic [5:0] POS_VAL_FIRST  = 6'h19;
  localparam logic [5:0] POS_VAL_LAST   = 6'h28;
  localparam logic [5:0] POS_EXT_FIRST  = 6'h02;
  localparam logic [5:0] POS_EXT_LAST   = 6'h21;
  localparam logic [5:0] CFG_LAST_BYTE  = 6'h29;
  localparam logic [5:0] EXT_LAST_BYTE  = 6'h21;
  localparam logic [5:0] POS_MAX        = 6'h3F;

  ////////////////////////////////////////////////////////////////////////////
  // Completion status
  localparam logic [3:0]  KEY_NONE      = 4'h0;
  localparam logic [3:0]  KEY_ILLEGAL   = 4'h5;
  localparam logic [7:0]  ASC_NONE      = 8'h00;
  localparam logic [7:0]  ASC_BAD_CDB   = 8'h24;
  localparam logic [7:0]  ASC_BAD_PARAM = 8'h26;
  localparam logic [7:0]  ASCQ_ZERO     = 8'h00;
  localparam logic [15:0] FPTR_NONE     = 16'h0000;
  localparam logic [15:0] FPTR_PAGE     = 16'h0002;
  localparam logic [15:0] FPTR_NAME     = 16'h0004;

  ////////////////////////////////////////////////////////////////////////////
  // Variable table
  localparam int          NVAR          = 5;
  localparam logic [2:0]  VAR_LAST      = 3'h4;
  localparam logic [2:0]  VAR_FIRST     = 3'h0;
  localparam logic [1:0]  TYPE_ASCII    = 2'h0;
  localparam logic [1:0]  TYPE_BYTES    = 2'h1;
  localparam logic [1:0]  TYPE_SIGNED   = 2'h2;
  localparam logic [1:0]  TYPE_UNSIGNED = 2'h3;

  typedef struct packed {
    logic             writable;
    logic [1:0]       vtype;
    logic [4:0]       vlen;
    logic [0:19][7:0] name;
    logic [0:15][7:0] value;
  } var_entry_s;

  // Entries stand in name order so that successive reads walk them sorted
  localparam var_entry_s VAR_TABLE [NVAR] = '{
    '{1'b0, TYPE_UNSIGNED, 5'h02, {"ELEMENT_BASE", 64'h0}, {16'h03E8, 112'h0}},
    '{1'b1, TYPE_ASCII,    5'h00, {"LIBRARY_NAME", 64'h0}, {"LIB0", 96'h0}},
    '{1'b1, TYPE_UNSIGNED, 5'h01, {"SCSI_ID", 104'h0},     {8'h04, 120'h0}},
    '{1'b0, TYPE_BYTES,    5'h04, {"SERIAL_TAG", 80'h0},   {32'hA1B2C3D4, 96'h0}},
    '{1'b1, TYPE_SIGNED,   5'h01, {"TEMP_OFFSET", 72'h0},  {8'hFE, 120'h0}}
  };

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_LOAD = 3'b001,
    ST_SEND = 3'b010,
    ST_RECV = 3'b011,
    ST_DONE = 3'b100
  } resp_state_e;

endpackage : mpr_pkg

/* mpr_if.sv */
// Carriers between the responder and its two stores.
// Assumes the responder drives addresses and the stores answer combinationally.
interface var_table_if;
  import mpr_pkg::*;
  logic [5:0]            addr;
  logic [NVAR-1:0][7:0]  bytes;
  modport reader (output addr, input bytes);
  modport src    (input addr, output bytes);
endinterface : var_table_if

////////////////////////////////////////////////////////////////////////////////
interface ext_store_if;
  logic [4:0] rd_addr;
  logic [7:0] rd_data;
  logic       we;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;
  modport ctrl  (output rd_addr, output we, output wr_addr, output wr_data, input rd_data);
  modport store (input rd_addr, input we, input wr_addr, input wr_data, output rd_data);
endinterface : ext_store_if

/* config_var_table.sv */
// Configuration page image of every variable, one byte lane per entry.
// Assumes the reader presents a page byte position; answers combinationally.
module config_var_table
  import mpr_pkg::*;
(
  var_table_if.src tbl  // Byte position in, one page byte per variable out
);

  ////////////////////////////////////////////////////////////////////////////
  for (genvar i = 0; i < NVAR; i++) begin : g_entry
    logic [7:0] page_byte;
    always_comb begin
      page_byte = 8'h00;
      if (tbl.addr == POS_CODE) begin
        page_byte = {SAVABLE_FLAG, 1'b0, PAGE_CFG};  // see RULE1 see RULE3
      end else if (tbl.addr == POS_LEN) begin
        page_byte = CFG_PARAM_LEN;  // see RULE2
      end else if (tbl.addr == POS_ATTR) begin
        // Write permission, type and length packed into one byte
        page_byte = {VAR_TABLE[i].writable, VAR_TABLE[i].vtype, VAR_TABLE[i].vlen};  // see RULE4 see RULE9 see RULE16
      end else if (tbl.addr >= POS_NAME_FIRST && tbl.addr <= POS_NAME_LAST) begin
        // Zero padding doubles as terminator, so a 20 character name ends at byte 24
        page_byte = VAR_TABLE[i].name[5'(tbl.addr - POS_NAME_FIRST)];  // see RULE10 see RULE16
      end else if (tbl.addr >= POS_VAL_FIRST && tbl.addr <= POS_VAL_LAST) begin
        // Values are stored left aligned, so integers go out most significant byte first
        page_byte = VAR_TABLE[i].value[4'(tbl.addr - POS_VAL_FIRST)];  // see RULE5 see RULE6 see RULE7 see RULE8
      end
    end
    assign tbl.bytes[i] = page_byte;
  end

endmodule : config_var_table

/* ext_data_store.sv */
// Thirty-two byte user store behind the external data page.
// Assumes write strobes come only from a mode select of that page.
module ext_data_store
  import mpr_pkg::*;
(
  input  wire logic    clk,   // System clock
  input  wire logic    rst,   // Asynchronous reset, active high
  ext_store_if.store   port   // Read and write port
);

  typedef struct packed {
    logic [31:0][7:0] mem;
  } store_s;

  store_s st;
  store_s next_st;

  ////////////////////////////////////////////////////////////////////////////
  // Between resets, contents are touched only by the write strobe
  always_comb begin
    next_st = st;
    if (port.we) begin
      next_st.mem[port.wr_addr] = port.wr_data;  // see RULE11
    end
  end

  // Flip-flops clear at reset; keeping them across power loss is up to the cell library
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign port.rd_data = st.mem[port.rd_addr];

endmodule : ext_data_store

/* mpr_checker_assertions.sv */
// Port checker for the mode page responder.
// Assumes one clock domain; bound to the top module at the foot.
module mpr_checker
  import mpr_pkg::*;
(
  input wire logic        CLK_SYS,    // Clock
  input wire logic        RST,        // Reset
  input wire logic        CMD_VALID,  // Command offered
  input wire logic        CMD_READY,  // Command ready
  input wire logic        CMD_SENSE,  // Sense or select
  input wire logic [5:0]  CMD_PAGE,   // Page code
  input wire logic        SEL_VALID,  // Select byte offered
  input wire logic        SEL_READY,  // Select ready
  input wire logic        SEL_LAST,   // Last select byte
  input wire logic        SNS_VALID,  // Sense byte offered
  input wire logic        SNS_READY,  // Sense ready
  input wire logic [7:0]  SNS_DATA,   // Sense byte
  input wire logic        SNS_LAST,   // Last sense byte
  input wire logic        DONE,       // Finish pulse
  input wire logic        DONE_CHECK, // Check condition
  input wire logic [3:0]  SENSE_KEY,  // Sense key
  input wire logic [7:0]  SENSE_ASC,  // Additional code
  input wire logic [7:0]  SENSE_ASCQ, // Qualifier
  input wire logic        SENSE_CD,   // Command block bit
  input wire logic [15:0] SENSE_FPTR  // Field pointer
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RST);
  logic [5:0] idx;
  logic [5:0] pg;
  wire        take = CMD_VALID && CMD_READY;
  wire        sb   = SNS_VALID && SNS_READY;
  // Byte position of the sense stream, restarted by each command
  always_ff @(posedge CLK_SYS or posedge RST) begin
    if (RST) begin
      idx <= 6'h00;
      pg  <= 6'h00;
    end else if (take) begin
      idx <= 6'h00;
      pg  <= CMD_PAGE;
    end else if (sb) begin
      idx <= idx + 6'h01;
    end
  end
  sequence sense_go(logic [5:0] p);
    take && CMD_SENSE && CMD_PAGE == p;
  endsequence
  sequence bad_take;
    take && CMD_PAGE != PAGE_CFG && CMD_PAGE != PAGE_EXT;
  endsequence
  ////////////////////////////////////////////////////////////////////////////
  bad_page_a: assert property (bad_take |=> DONE && DONE_CHECK && SENSE_KEY == 4'h5 && SENSE_ASC == 8'h24
    && SENSE_ASCQ == 8'h00 && SENSE_CD && SENSE_FPTR == 16'h0002) else $error("bad page status");
  cfg_code_a: assert property (sense_go(PAGE_CFG) |-> ##2 SNS_VALID && SNS_DATA == 8'hBD)
    else $error("config page byte 0");
  ext_code_a: assert property (sense_go(PAGE_EXT) |-> ##2 SNS_VALID && SNS_DATA == 8'hBE)
    else $error("external page byte 0");
  len_byte_a: assert property (sb && idx == 6'h01 |-> SNS_DATA == (pg == PAGE_CFG ? 8'h28 : 8'h20))
    else $error("length byte");
  last_byte_a: assert property (sb |-> SNS_LAST == (idx == (pg == PAGE_CFG ? 6'h29 : 6'h21)))
    else $error("last byte position");
  zero_pad_a: assert property (sb && pg == PAGE_CFG && (idx == 6'h03 || idx == 6'h18 || idx == 6'h29)
    |-> SNS_DATA == 8'h00) else $error("zero byte");
  sense_end_a: assert property (sb && SNS_LAST |=> DONE && !DONE_CHECK) else $error("sense finish");
  hold_data_a: assert property (SNS_VALID && !SNS_READY |=> SNS_VALID && $stable(SNS_DATA)) else $error("data held");
  sel_end_a: assert property (SEL_VALID && SEL_READY && SEL_LAST |=> DONE) else $error("select finish");
  busy_cmd_a: assert property (take |=> !CMD_READY) else $error("busy");
  done_pulse_a: assert property (DONE |-> !CMD_READY ##1 !DONE && CMD_READY) else $error("done pulse");
endmodule : mpr_checker

bind mode_page_responder mpr_checker i_mpr_checker (.CLK_SYS, .RST, .CMD_VALID, .CMD_READY, .CMD_SENSE,
  .CMD_PAGE, .SEL_VALID, .SEL_READY, .SEL_LAST, .SNS_VALID, .SNS_READY, .SNS_DATA, .SNS_LAST, .DONE,
  .DONE_CHECK, .SENSE_KEY, .SENSE_ASC, .SENSE_ASCQ, .SENSE_CD, .SENSE_FPTR);

/* host_model.sv */
// Initiator model: issues mode commands, streams select bytes, drains sense.
// Assumes valid and ready meet on the rising edge; drives just after it.
module host_model
  import mpr_pkg::*;
(
  input  wire logic        clk,       // Clock
  output logic             cmd_valid, // Command offered
  input  wire logic        cmd_ready, // Command taken
  output logic             cmd_sense, // Sense or select
  output logic [5:0]       cmd_page,  // Page code
  output logic             sel_valid, // Select byte offered
  input  wire logic        sel_ready, // Select byte taken
  output logic [7:0]       sel_data,  // Select byte
  output logic             sel_last,  // Last select byte
  input  wire logic        sns_valid, // Sense byte offered
  output logic             sns_ready, // Sense byte taken
  input  wire logic [7:0]  sns_data,  // Sense byte
  input  wire logic        sns_last,  // Last sense byte
  input  wire logic        done,      // Finish pulse
  input  wire logic [37:0] stat       // Status lines
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [7:0]  tx [0:63];
  logic [7:0]  rx [0:63];
  int          rx_n;
  logic [37:0] got;
  initial begin
    cmd_valid = 1'b0;
    cmd_sense = 1'b0;
    cmd_page  = 6'h00;
    sel_valid = 1'b0;
    sel_data  = 8'h00;
    sel_last  = 1'b0;
    sns_ready = 1'b0;
  end
  task automatic cmd(input logic s, input logic [5:0] p);
    int k;
    k = 0;
    @(posedge clk);
    #1;
    cmd_valid = 1'b1;
    cmd_sense = s;
    cmd_page  = p;
    do begin
      @(posedge clk);
      k++;
    end while (!cmd_ready && k < 500);
    #1;
    cmd_valid = 1'b0;
    // Released page code is inverted so it never keeps the last value
    cmd_page  = ~p;
  endtask : cmd
  task automatic send(input int n);
    int i;
    int k;
    i = 0;
    k = 0;
    sel_valid = 1'b1;
    sel_data  = tx[0];
    sel_last  = (n == 1);
    while (i < n && k < 500) begin
      @(posedge clk);
      k++;
      if (sel_ready) begin
        i++;
        #1;
        sel_data  = (i < n) ? tx[i] : ~sel_data;
        sel_last  = (i == n - 1);
        sel_valid = (i < n);
      end
    end
  endtask : send
  // Stall pattern: ready only every stall-th cycle, 0 for always ready
  task automatic recv(input int stall);
    int k;
    rx_n = 0;
    k = 0;
    sns_ready = (stall == 0);
    while (k < 500) begin
      @(posedge clk);
      k++;
      if (sns_valid && sns_ready) begin
        rx[rx_n[5:0]] = sns_data;
        rx_n++;
        if (sns_last) break;
      end
      #1;
      sns_ready = (stall == 0) || (k % stall == 0);
    end
    #1;
    sns_ready = 1'b0;
  endtask : recv
  task automatic wait_done();
    int k;
    k = 0;
    do begin
      @(posedge clk);
      k++;
    end while (!done && k < 500);
    got = done ? stat : 'x;
    #1;
  endtask : wait_done
  task automatic put_name(input string s);
    for (int i = 0; i < 64; i++) tx[i] = 8'h00;
    tx[0] = 8'hBD;
    tx[1] = 8'h28;
    for (int i = 0; i < s.len(); i++) tx[i + 4] = s[i];
  endtask : put_name
endmodule : host_model

/* testbench.sv */
// Self-checking bench for the mode page responder.
// Assumes the host model drives every command-side input.
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  import mpr_pkg::*;
  localparam logic [37:0] ST_BAD  = {1'b1, KEY_ILLEGAL, ASC_BAD_CDB, ASCQ_ZERO, 1'b1, FPTR_PAGE};
  localparam logic [37:0] ST_MISS = {1'b1, KEY_ILLEGAL, ASC_BAD_PARAM, ASCQ_ZERO, 1'b0, FPTR_NAME};
  logic clk_sys, rst, cmd_valid, cmd_ready, cmd_sense, sel_valid, sel_ready, sel_last;
  logic sns_valid, sns_ready, sns_last, done, done_check, sense_cd;
  logic [5:0]  cmd_page;
  logic [7:0]  sel_data, sns_data, sense_asc, sense_ascq;
  logic [3:0]  sense_key;
  logic [15:0] sense_fptr;
  int          fails;
  int          compares;
  mode_page_responder i_mode_page_responder (.CLK_SYS(clk_sys), .RST(rst), .CMD_VALID(cmd_valid),
    .CMD_READY(cmd_ready), .CMD_SENSE(cmd_sense), .CMD_PAGE(cmd_page), .SEL_VALID(sel_valid),
    .SEL_READY(sel_ready), .SEL_DATA(sel_data), .SEL_LAST(sel_last), .SNS_VALID(sns_valid),
    .SNS_READY(sns_ready), .SNS_DATA(sns_data), .SNS_LAST(sns_last), .DONE(done), .DONE_CHECK(done_check),
    .SENSE_KEY(sense_key), .SENSE_ASC(sense_asc), .SENSE_ASCQ(sense_ascq), .SENSE_CD(sense_cd),
    .SENSE_FPTR(sense_fptr));
  host_model i_host_model (.clk(clk_sys), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .cmd_sense(cmd_sense), .cmd_page(cmd_page), .sel_valid(sel_valid), .sel_ready(sel_ready),
    .sel_data(sel_data), .sel_last(sel_last), .sns_valid(sns_valid), .sns_ready(sns_ready),
    .sns_data(sns_data), .sns_last(sns_last), .done(done),
    .stat({done_check, sense_key, sense_asc, sense_ascq, sense_cd, sense_fptr}));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    if (fails == 0 && compares > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : wrap_up
  task automatic chk8(input logic [7:0] g, input logic [7:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: byte %h expected %h", $time, g, e);
    end
  endtask : chk8
  task automatic chkst(input logic [37:0] g, input logic [37:0] e);
    compares++;
    if (g !== e) begin
      fails++;
      $display("wrong value at %0t: status %h expected %h", $time, g, e);
    end
  endtask : chkst
  function automatic logic [7:0] pat(input int i);
    return 8'(i * 37 + 17);
  endfunction : pat
  function automatic logic [7:0] cfg_byte(input int v, input int b);
    if (b == 0) return 8'hBD;
    if (b == 1) return 8'h28;
    if (b == 2) return {VAR_TABLE[v].writable, VAR_TABLE[v].vtype, VAR_TABLE[v].vlen};
    if (b >= 4 && b <= 23) return VAR_TABLE[v].name[b - 4];
    if (b >= 25 && b <= 40) return VAR_TABLE[v].value[b - 25];
    return 8'h00;
  endfunction : cfg_byte
  ////////////////////////////////////////////////////////////////////////////
  task automatic t_bad_pages();
    logic [5:0] pg [4];
    pg = '{6'h00, 6'h1F, 6'h3C, 6'h3F};
    for (int i = 0; i < 8; i++) begin
      i_host_model.cmd(i[0], pg[i / 2]);
      i_host_model.wait_done();
      chkst(i_host_model.got, ST_BAD);
    end
  endtask : t_bad_pages
  task automatic t_ext_write();
    i_host_model.tx[0] = 8'hBE;
    i_host_model.tx[1] = 8'h20;
    for (int i = 0; i < 32; i++) i_host_model.tx[i + 2] = pat(i);
    // A byte past the page end must not land anywhere
    i_host_model.tx[34] = 8'hFF;
    i_host_model.cmd(1'b0, PAGE_EXT);
    i_host_model.send(35);
    i_host_model.wait_done();
    chk8({7'h0, i_host_model.got[37]}, 8'h00);
  endtask : t_ext_write
  task automatic t_ext_read(input logic wr);
    i_host_model.cmd(1'b1, PAGE_EXT);
    i_host_model.recv(3);
    i_host_model.wait_done();
    chk8(8'(i_host_model.rx_n), 8'h22);
    chk8(i_host_model.rx[0], 8'hBE);
    chk8(i_host_model.rx[1], 8'h20);
    for (int i = 0; i < 32; i++) chk8(i_host_model.rx[i + 2], wr ? pat(i) : 8'h00);
  endtask : t_ext_read
  task automatic cfg_sense(input int v);
    i_host_model.cmd(1'b1, PAGE_CFG);
    i_host_model.recv(0);
    i_host_model.wait_done();
    chk8(8'(i_host_model.rx_n), 8'h2A);
    for (int b = 0; b < 42; b++) chk8(i_host_model.rx[b], cfg_byte(v, b));
  endtask : cfg_sense
  task automatic t_cfg_walk();
    i_host_model.put_name("LIBRARY_NAME");
    i_host_model.cmd(1'b0, PAGE_CFG);
    i_host_model.send(42);
    i_host_model.wait_done();
    chk8({7'h0, i_host_model.got[37]}, 8'h00);
    for (int i = 0; i < 6; i++) cfg_sense((i + 1) % NVAR);
  endtask : t_cfg_walk
  task automatic t_name_miss();
    i_host_model.put_name("NO_SUCH_VAR");
    i_host_model.cmd(1'b0, PAGE_CFG);
    i_host_model.send(42);
    i_host_model.wait_done();
    chkst(i_host_model.got, ST_MISS);
    // Pointer kept: the walk left it on entry 2
    cfg_sense(2);
  endtask : t_name_miss
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
  initial begin
    fails = 0;
    compares = 0;
    rst = 1'b1;
    repeat (20) @(posedge clk_sys);
    #1;
    rst = 1'b0;
    t_bad_pages();
    t_ext_read(1'b0);
    t_ext_write();
    t_ext_read(1'b1);
    t_cfg_walk();
    t_name_miss();
    t_ext_read(1'b1);
    wrap_up();
  end
endmodule : testbench
